// File: hdl/flash_led_control_regs.sv
// Summary of operation
// - Control pin held low over 10 ms: disabled, registers at default
// - Sink off: sleep, pump stopped, clock runs only while a frame is received
// - Regulators may run during sleep
// - Overtemperature disables outputs, registers kept
// - Open sink while on: turn sink off
// - Flash register 0x02 layout, reset 0x10
// - Timeout enable set after reset
// - Timeout: sink off after one second on
// - Re-arm by trigger falling edge or a write of code zero
// - Low range: off, 50..200, then 250 mA
// - High range: off, 300, 350, then 400
// - Trigger pin high turns flash on
// - Write: 5 address, 8 data bits, MSB first
`default_nettype none
module flash_led_control_regs (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Pins from outside
  input wire logic single_wire_ctrl_pin_in,
  input wire logic flash_trigger_pin_in,
  input wire logic overtemp_guard_in,
  input wire logic sink_open_in,
  // Sink and regulator controls
  output logic sink_enable_out,
  output logic [8:0] sink_current_ma_out,
  output logic [3:0] regulator_a_code_out,
  output logic [2:0] regulator_b_code_out,
  output logic osc_run_out,
  output logic pump_run_out,
  output logic device_enabled_out,
  output logic timeout_hit_out
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] swire_sync;
  logic [1:0] trig_sync;
  logic [1:0] ot_sync;
  logic [1:0] open_sync;
  always_ff @(posedge mclk_in) begin
    swire_sync <= {swire_sync[0], single_wire_ctrl_pin_in};
    trig_sync <= {trig_sync[0], flash_trigger_pin_in};
    ot_sync <= {ot_sync[0], overtemp_guard_in};
    open_sync <= {open_sync[0], sink_open_in};
  end
  wire logic swire = swire_sync[1];
  wire logic trig = trig_sync[1];
  wire logic hot = ot_sync[1];
  wire logic sink_open = open_sync[1];

  function automatic logic [8:0] code_to_ma(input logic [2:0] code, input logic range_hi);
    logic [8:0] ma;
    ma = 9'h000;
    if (code == 3'h0) begin
      ma = 9'h000;
    end else if (!range_hi) begin
      if (code >= 3'h5) begin
        ma = flash_led_pkg::MA_SPOT_MAX;
      end else begin
        ma = 9'(flash_led_pkg::MA_STEP * code);
      end
    end else begin
      if (code >= 3'h3) begin
        ma = flash_led_pkg::MA_FLASH_MAX;
      end else begin
        ma = 9'(flash_led_pkg::MA_FLASH_BASE + flash_led_pkg::MA_STEP * code);
      end
    end
    return ma;
  endfunction

  // ----------------------------------------
  // Shutdown detect
  // ----------------------------------------
  // A short low is a frame bit; only a long low shuts down
  logic [19:0] low_cnt, next_low_cnt;
  logic enabled, next_enabled;
  always_comb begin
    next_low_cnt = low_cnt;
    next_enabled = enabled;
    if (swire) begin
      next_low_cnt = 20'h00000;
      next_enabled = 1'b1;
    end else if (low_cnt < 20'(flash_led_pkg::SHUTDOWN_CYCLES)) begin
      next_low_cnt = low_cnt + 20'h00001;
    end else begin
      next_enabled = 1'b0;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_cnt <= 20'h00000;
      enabled <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      enabled <= next_enabled;
    end
  end

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  // Bit time measured from the sample low phase; sampled mid-bit
  typedef enum {ST_IDLE, ST_WAKE, ST_MEASURE_LO, ST_MEASURE_HI, ST_START, ST_SHIFT, ST_STANDBY} rx_state_e;
  rx_state_e st, next_st;
  logic prev_line, next_prev_line;
  logic [15:0] cnt, next_cnt;
  logic [15:0] bit_len, next_bit_len;
  logic [3:0] nbits, next_nbits;
  logic [12:0] shreg, next_shreg;
  logic wr_stb, next_wr_stb;
  always_comb begin
    next_st = st;
    next_prev_line = swire;
    next_cnt = cnt + 16'h0001;
    next_bit_len = bit_len;
    next_nbits = nbits;
    next_shreg = shreg;
    next_wr_stb = 1'b0;
    case (st)
      ST_IDLE: begin
        if (prev_line && !swire) begin
          next_st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (prev_line && !swire) begin
          next_st = ST_MEASURE_LO;
          next_cnt = 16'h0001;
        end
      end
      ST_MEASURE_LO: begin
        if (swire) begin
          next_bit_len = cnt;
          next_st = ST_MEASURE_HI;
        end
      end
      ST_MEASURE_HI: begin
        if (!swire) begin
          next_st = ST_START;
          next_cnt = 16'h0001;
        end
      end
      ST_START: begin
        if (cnt >= bit_len + (bit_len >> 1)) begin
          next_st = ST_SHIFT;
          next_cnt = 16'h0000;
          next_nbits = 4'h0;
          next_shreg = {shreg[11:0], swire};
          next_nbits = 4'h1;
        end
      end
      ST_SHIFT: begin
        if (cnt >= bit_len - 16'h0001) begin
          next_cnt = 16'h0000;
          if (nbits == 4'(flash_led_pkg::FRAME_BITS)) begin
            next_st = ST_STANDBY;
            next_wr_stb = 1'b1;
          end else begin
            next_shreg = {shreg[11:0], swire};
            next_nbits = nbits + 4'h1;
          end
        end
      end
      default: begin
        // A following frame may start at once; its first fall is the wake edge
        if (prev_line && !swire) begin
          next_st = ST_WAKE;
        end else if (cnt >= 16'(flash_led_pkg::STANDBY_BITS) * bit_len) begin
          next_st = ST_IDLE;
        end
      end
    endcase
    if (!enabled) begin
      next_st = ST_IDLE;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st <= ST_IDLE;
      prev_line <= 1'b0;
      cnt <= 16'h0000;
      bit_len <= 16'h0000;
      nbits <= 4'h0;
      shreg <= 13'h0000;
      wr_stb <= 1'b0;
    end else begin
      st <= next_st;
      prev_line <= next_prev_line;
      cnt <= next_cnt;
      bit_len <= next_bit_len;
      nbits <= next_nbits;
      shreg <= next_shreg;
      wr_stb <= next_wr_stb;
    end
  end

  // ----------------------------------------
  // Registers and sink control
  // ----------------------------------------
  logic [7:0] flash_spot, next_flash_spot;
  logic [7:0] regulator, next_regulator;
  logic tripped, next_tripped;
  logic trig_prev, next_trig_prev;
  logic [24:0] on_cnt, next_on_cnt;
  logic [2:0] sink_code;
  logic sink_req;
  assign sink_code = flash_spot[flash_led_pkg::FLD_CODE_HI:flash_led_pkg::FLD_CODE_LO];
  // Trigger pin requests the flash even with code zero at lowest nonzero step
  assign sink_req = (sink_code != 3'h0) || trig;
  always_comb begin
    next_flash_spot = flash_spot;
    next_regulator = regulator;
    next_tripped = tripped;
    next_on_cnt = on_cnt;
    next_trig_prev = trig;
    if (wr_stb) begin
      if (shreg[12:8] == flash_led_pkg::ADDR_FLASH_SPOT) begin
        next_flash_spot = {3'h0, shreg[4:0]};
        if (shreg[3:1] == 3'h0) begin
          next_tripped = 1'b0;
        end
      end else if (shreg[12:8] == flash_led_pkg::ADDR_REGULATOR) begin
        next_regulator = {1'b0, shreg[6:0]};
      end
    end
    // Only the falling edge re-arms; a pin that stays low must not undo a trip
    if (trig_prev && !trig) begin
      next_tripped = 1'b0;
    end
    if (sink_req && !tripped && flash_spot[flash_led_pkg::FLD_TIMEOUT_EN] && !hot) begin
      if (on_cnt >= 25'(flash_led_pkg::TIMEOUT_CYCLES - 1)) begin
        next_tripped = 1'b1;
      end else begin
        next_on_cnt = on_cnt + 25'h0000001;
      end
    end else begin
      next_on_cnt = 25'h0000000;
    end
    if (sink_req && sink_open) begin
      next_tripped = 1'b1;
    end
    if (!enabled) begin
      next_flash_spot = flash_led_pkg::FLASH_SPOT_RESET;
      next_regulator = flash_led_pkg::REGULATOR_RESET;
      next_tripped = 1'b0;
      next_on_cnt = 25'h0000000;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      flash_spot <= flash_led_pkg::FLASH_SPOT_RESET;
      regulator <= flash_led_pkg::REGULATOR_RESET;
      tripped <= 1'b0;
      on_cnt <= 25'h0000000;
      trig_prev <= 1'b0;
    end else begin
      flash_spot <= next_flash_spot;
      regulator <= next_regulator;
      tripped <= next_tripped;
      trig_prev <= next_trig_prev;
      on_cnt <= next_on_cnt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic sink_on;
  logic [2:0] eff_code;
  assign sink_on = enabled && sink_req && !tripped && !hot;
  assign eff_code = (sink_code == 3'h0) ? 3'h1 : sink_code;
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sink_enable_out <= 1'b0;
      sink_current_ma_out <= 9'h000;
      regulator_a_code_out <= 4'h0;
      regulator_b_code_out <= 3'h0;
      osc_run_out <= 1'b0;
      pump_run_out <= 1'b0;
      device_enabled_out <= 1'b0;
      timeout_hit_out <= 1'b0;
    end else begin
      sink_enable_out <= sink_on;
      sink_current_ma_out <= sink_on ? code_to_ma(eff_code, flash_spot[flash_led_pkg::FLD_RANGE]) : 9'h000;
      // Regulators follow their codes in sleep too, but drop on overheating
      regulator_a_code_out <= (enabled && !hot) ?
        regulator[flash_led_pkg::FLD_REG_A_HI:flash_led_pkg::FLD_REG_A_LO] : 4'h0;
      regulator_b_code_out <= (enabled && !hot) ?
        regulator[flash_led_pkg::FLD_REG_B_HI:flash_led_pkg::FLD_REG_B_LO] : 3'h0;
      // Oscillator also runs while a frame is being received
      osc_run_out <= sink_on || (st != rx_state_e'(ST_IDLE) && st != rx_state_e'(ST_WAKE));
      pump_run_out <= sink_on;
      device_enabled_out <= enabled;
      timeout_hit_out <= tripped;
    end
  end
endmodule // flash_led_control_regs
`default_nettype wire

// File: hdl/flash_led_pkg.sv
`default_nettype none
package flash_led_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int SHUTDOWN_MS = 10;
  localparam int SHUTDOWN_CYCLES = (CLK_HZ / 1000) * SHUTDOWN_MS + 1;
  localparam int BIT_CYCLES_MIN = 20;
  localparam int STANDBY_BITS = 5;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] ADDR_FLASH_SPOT = 5'h02;
  localparam logic [4:0] ADDR_REGULATOR = 5'h03;
  localparam logic [7:0] FLASH_SPOT_RESET = 8'h10;
  localparam logic [7:0] REGULATOR_RESET = 8'h00;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLD_RANGE = 0;
  localparam int FLD_CODE_LO = 1;
  localparam int FLD_CODE_HI = 3;
  localparam int FLD_TIMEOUT_EN = 4;
  localparam int FLD_REG_A_LO = 0;
  localparam int FLD_REG_A_HI = 3;
  localparam int FLD_REG_B_LO = 4;
  localparam int FLD_REG_B_HI = 6;
  // ----------------------------------------
  // Sink current in mA
  // ----------------------------------------
  localparam logic [8:0] MA_STEP = 9'h032;
  localparam logic [8:0] MA_SPOT_MAX = 9'h0FA;
  localparam logic [8:0] MA_FLASH_BASE = 9'h0FA;
  localparam logic [8:0] MA_FLASH_MAX = 9'h190;
endpackage
`default_nettype wire

// File: verification/flash_led_control_regs_props.sv
`default_nettype none
// ----------------------------------------
// Port checker for the control block
// ----------------------------------------
module flash_led_control_regs_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Pins
  input wire logic single_wire_ctrl_pin_in,
  input wire logic flash_trigger_pin_in,
  input wire logic overtemp_guard_in,
  input wire logic sink_open_in,
  // Outputs
  input wire logic sink_enable_out,
  input wire logic [8:0] sink_current_ma_out,
  input wire logic [3:0] regulator_a_code_out,
  input wire logic [2:0] regulator_b_code_out,
  input wire logic osc_run_out,
  input wire logic pump_run_out,
  input wire logic device_enabled_out,
  input wire logic timeout_hit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  a_reset_clears: assert property ($past(srst_in) |-> !sink_enable_out && regulator_a_code_out == 4'h0)
    else $error("outputs not clear after reset");
  a_pump_follows_sink: assert property (pump_run_out == sink_enable_out) else $error("pump differs from sink");
  a_osc_with_pump: assert property (pump_run_out |-> osc_run_out) else $error("pump runs without clock");
  a_off_means_zero: assert property (!sink_enable_out |-> sink_current_ma_out == 9'h000) else $error("current when off");
  a_on_legal_current: assert property (sink_enable_out |-> sink_current_ma_out inside {9'h032, 9'h064, 9'h096,
    9'h0C8, 9'h0FA, 9'h12C, 9'h15E, 9'h190}) else $error("illegal sink current");
  a_hot_all_off: assert property (overtemp_guard_in [*5] |=> !sink_enable_out && regulator_a_code_out == 4'h0
    && regulator_b_code_out == 3'h0) else $error("outputs on while hot");
  a_open_sink_off: assert property (sink_open_in [*5] |=> !sink_enable_out) else $error("sink on with open load");
  a_disabled_all_off: assert property (!device_enabled_out |-> !sink_enable_out && regulator_b_code_out == 3'h0)
    else $error("outputs on while disabled");
  a_hit_holds_off: assert property (timeout_hit_out |-> !sink_enable_out) else $error("sink on after latch-off");
  a_trigger_turns_on: assert property ((flash_trigger_pin_in && device_enabled_out && !overtemp_guard_in
    && !sink_open_in && !timeout_hit_out) [*6] |=> sink_enable_out) else $error("trigger ignored");
endmodule // flash_led_control_regs_props
bind flash_led_control_regs flash_led_control_regs_props u_props (.*);
`default_nettype wire

// File: verification/swire_host_model.sv
`default_nettype none
// ----------------------------------------
// Host driving the single-wire pin
// ----------------------------------------
module swire_host_model (
  // Clock
  input wire logic mclk_in,
  // Pin
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin_out = 1'b0;
  // Level changes only at a rising edge, so the device sync never sees a half cycle
  task automatic hold(input logic lvl, input int cycles);
    pin_out <= lvl;
    repeat (cycles) @(posedge mclk_in);
  endtask
  // Bit time is an argument so a slow host can be modelled too
  task automatic write_frame(input logic [4:0] addr, input logic [7:0] data, input int len);
    logic [12:0] word;
    word = {addr, data};
    repeat (2) begin
      hold(1'b0, len);
      hold(1'b1, len);
    end
    hold(1'b0, len);
    for (int i = 12; i >= 0; i--) hold(word[i], len);
    hold(1'b1, 5 * len);
  endtask
endmodule // swire_host_model
`default_nettype wire

// File: verification/tb_flash_led_control_regs.sv
`default_nettype none
module tb_flash_led_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals, rows and tasks
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  wire logic single_wire_ctrl_pin_in;
  logic flash_trigger_pin_in = 1'b0;
  logic overtemp_guard_in = 1'b0;
  logic sink_open_in = 1'b0;
  logic sink_enable_out, osc_run_out, pump_run_out, device_enabled_out, timeout_hit_out;
  logic [8:0] sink_current_ma_out;
  logic [3:0] regulator_a_code_out;
  logic [2:0] regulator_b_code_out;
  int error_cnt = 0;
  int check_count = 0;
  // Flash register value beside the sink current it should give; top three bits zero
  logic [16:0] rows [16] = '{{8'h10, 9'h000}, {8'h12, 9'h032}, {8'h14, 9'h064}, {8'h16, 9'h096},
    {8'h18, 9'h0C8}, {8'h1A, 9'h0FA}, {8'h1C, 9'h0FA}, {8'h1E, 9'h0FA}, {8'h11, 9'h000}, {8'h13, 9'h12C},
    {8'h15, 9'h15E}, {8'h17, 9'h190}, {8'h19, 9'h190}, {8'h1B, 9'h190}, {8'h1D, 9'h190}, {8'h1F, 9'h190}};
  logic [4:0] bad_addr [4] = '{5'h00, 5'h01, 5'h04, 5'h1F};
  flash_led_control_regs u_dut (.*);
  swire_host_model u_host (.mclk_in(mclk_in), .pin_out(single_wire_ctrl_pin_in));
  initial forever #20 mclk_in = ~mclk_in;
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input int len);
    @(posedge mclk_in);
    u_host.write_frame(a, d, len);
    @(negedge mclk_in);
  endtask
  // Covers the pin synchroniser plus the output register, with margin
  task automatic settle();
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic chk_out(input logic [8:0] ma, input logic [3:0] ra, input logic [2:0] rb);
    chk("sink ma", ma, sink_current_ma_out);
    chk("reg a", {5'h00, ra}, {5'h00, regulator_a_code_out});
    chk("reg b", {6'h00, rb}, {6'h00, regulator_b_code_out});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    u_host.hold(1'b1, 1);
    for (int i = 0; i < 40000 && device_enabled_out !== 1'b1; i++) @(posedge mclk_in);
    if (device_enabled_out !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH enable wait expected 1 seen %b", device_enabled_out);
      finish_test();
    end
    @(negedge mclk_in);
    chk_out(9'h000, 4'h0, 3'h0);
    foreach (rows[i]) begin
      wr(flash_led_pkg::ADDR_FLASH_SPOT, rows[i][16:9], 20);
      chk("row ma", rows[i][8:0], sink_current_ma_out);
      chk("row pump", {8'h00, rows[i][8:0] != 9'h000}, {8'h00, pump_run_out});
    end
    chk("short low", 9'h001, {8'h00, device_enabled_out});
    wr(flash_led_pkg::ADDR_REGULATOR, 8'h45, 40);
    chk_out(9'h190, 4'h5, 3'h4);
    wr(flash_led_pkg::ADDR_FLASH_SPOT, 8'h10, 20);
    chk_out(9'h000, 4'h5, 3'h4);
    chk("sleep pump", 9'h000, {8'h00, pump_run_out});
    foreach (bad_addr[i]) begin
      wr(bad_addr[i], 8'h1F, 20);
      chk_out(9'h000, 4'h5, 3'h4);
    end
    @(posedge mclk_in);
    flash_trigger_pin_in <= 1'b1;
    settle();
    chk("trigger ma", 9'h032, sink_current_ma_out);
    chk("trigger osc", 9'h001, {8'h00, osc_run_out});
    @(posedge mclk_in);
    flash_trigger_pin_in <= 1'b0;
    settle();
    chk("trigger off", 9'h000, sink_current_ma_out);
    chk("sleep osc", 9'h000, {8'h00, osc_run_out});
    wr(flash_led_pkg::ADDR_FLASH_SPOT, 8'h18, 20);
    @(posedge mclk_in);
    overtemp_guard_in <= 1'b1;
    settle();
    chk_out(9'h000, 4'h0, 3'h0);
    @(posedge mclk_in);
    overtemp_guard_in <= 1'b0;
    settle();
    chk_out(9'h0C8, 4'h5, 3'h4);
    @(posedge mclk_in);
    sink_open_in <= 1'b1;
    settle();
    chk("open ma", 9'h000, sink_current_ma_out);
    chk("open hit", 9'h001, {8'h00, timeout_hit_out});
    @(posedge mclk_in);
    sink_open_in <= 1'b0;
    settle();
    chk("latched ma", 9'h000, sink_current_ma_out);
    wr(flash_led_pkg::ADDR_FLASH_SPOT, 8'h10, 20);
    wr(flash_led_pkg::ADDR_FLASH_SPOT, 8'h18, 20);
    chk("rearm ma", 9'h0C8, sink_current_ma_out);
    @(posedge mclk_in);
    sink_open_in <= 1'b1;
    settle();
    @(posedge mclk_in);
    sink_open_in <= 1'b0;
    flash_trigger_pin_in <= 1'b1;
    settle();
    chk("trip held", 9'h000, sink_current_ma_out);
    @(posedge mclk_in);
    flash_trigger_pin_in <= 1'b0;
    settle();
    chk("pin rearm", 9'h0C8, sink_current_ma_out);
    chk("pin rearm hit", 9'h000, {8'h00, timeout_hit_out});
    @(posedge mclk_in);
    srst_in <= 1'b1;
    @(posedge mclk_in);
    srst_in <= 1'b0;
    settle();
    chk_out(9'h000, 4'h0, 3'h0);
    finish_test();
  end
endmodule // tb_flash_led_control_regs
`default_nettype wire
